/* logic/fpt_pkg.sv */
// shared constants for the flow pulse totalizer
package fpt_pkg;

    ////////////////////////////////////////////////////////////////////////
    // clock and times
    localparam int unsigned CLK_KHZ       = 250000;
    localparam int unsigned KEY_LONG_MS   = 1000;
    localparam int unsigned RATE_TICK_MS  = 700;
    localparam int unsigned SHOW_MS       = 3000;
    localparam int unsigned IDLE_MS       = 2000;
    localparam int unsigned SEG_STEP_MS   = 500;

    // least times round up, whole ms at this rate needs no rounding
    localparam logic [31:0] KEY_LONG_CYC  = 32'(KEY_LONG_MS * CLK_KHZ);
    localparam logic [31:0] RATE_TICK_CYC = 32'(RATE_TICK_MS * CLK_KHZ);
    localparam logic [31:0] SHOW_CYC      = 32'(SHOW_MS * CLK_KHZ);
    localparam logic [31:0] IDLE_CYC      = 32'(IDLE_MS * CLK_KHZ);
    localparam logic [31:0] SEG_STEP_CYC  = 32'(SEG_STEP_MS * CLK_KHZ);

    ////////////////////////////////////////////////////////////////////////
    // rate scaling: units per minute from one sampling window
    localparam logic [63:0] MS_PER_MIN    = 64'h0000_0000_0000_EA60;
    localparam logic [63:0] RATE_DIV      = 64'(RATE_TICK_MS);

    ////////////////////////////////////////////////////////////////////////
    // six digit totals field with x10 / x100 indicators
    localparam logic [19:0] DIGITS_MAX    = 20'hF_423F;
    localparam logic [31:0] X1_LIMIT      = 32'h000F_423F;
    localparam logic [31:0] X10_LIMIT     = 32'h0098_967F;
    localparam logic [31:0] X100_LIMIT    = 32'h05F5_E0FF;

    ////////////////////////////////////////////////////////////////////////
    // retained store layout
    localparam int unsigned NV_DEPTH      = 4;
    localparam logic [1:0]  NV_PARTIAL    = 2'h0;
    localparam logic [1:0]  NV_RTOTAL     = 2'h1;
    localparam logic [1:0]  NV_LTOTAL     = 2'h2;
    localparam logic [31:0] RESET_VALUE   = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////
    // mode machine, one-hot
    typedef enum logic [7:0] {
        ST_RESTORE = 8'h01,
        ST_STANDBY = 8'h02,
        ST_COUNT   = 8'h04,
        ST_POSTCNT = 8'h08,
        ST_SEG_ON  = 8'h10,
        ST_SEG_OFF = 8'h20,
        ST_POSTCLR = 8'h40,
        ST_RATE    = 8'h80
    } fpt_state_t;

endpackage : fpt_pkg

/* logic/fpt_nv_mem.sv */
// small retained word store, registered read
`timescale 1ns/1ns

module fpt_nv_mem #(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned DEPTH = 4,
    parameter int unsigned AW    = 2
) (
    // clock and reset
    input  wire logic             i_sys_clk,
    input  wire logic             i_rst,
    input  wire logic             i_clk_en,
    // write port
    input  wire logic             i_we,
    input  wire logic [AW-1:0]    i_waddr,
    input  wire logic [WIDTH-1:0] i_wdata,
    // read port
    input  wire logic [AW-1:0]    i_raddr,
    output logic      [WIDTH-1:0] o_rdata
);

    // array has no reset: contents survive a reset of the logic
    logic [WIDTH-1:0] mem_q [DEPTH];

    always_ff @(posedge i_sys_clk)
    begin
        if (i_clk_en && i_we)
            mem_q[i_waddr] <= i_wdata;
    end

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
            o_rdata <= '0;
        else if (i_clk_en)
            o_rdata <= mem_q[i_raddr];
    end

endmodule : fpt_nv_mem

/* logic/fpt_totalizer.sv */
// flow pulse totalizer: accumulators, key mode machine, display select
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - each gear pulse adds the active calibration weight to the accumulators
// - partial holds volume since the reset key last cleared it
// - resettable total clears only right after a partial clear
// - lifetime total is cleared only by reset and never decreases between resets
// - lower area shows one total; lifetime total in standby
// - resettable total shown after clear, while and after dispensing
// - totals shown as six digits, then x10, then x100
// - keys ignored while counting in normal mode
// - reset key in standby clears the partial
// - normal clear: all segments on, off, then totals shown
// - reset held one second after a clear clears resettable total
// - short calibration key press in standby enters flow-rate mode
// - flow rate recomputed every 0.7 seconds in flow-rate mode
// - flow rate is in partial units per minute
// - further short calibration press returns to normal mode
// - keys ignored while counting in flow-rate mode
// - both totals keep counting in flow-rate mode
// - rate mode, rate zero: short reset clears partial, no segment test
// - totals may use a weight of their own unit
// - accumulated data retained in a store across power loss
module fpt_totalizer #(
    parameter logic [31:0] P_LONG_CYC = fpt_pkg::KEY_LONG_CYC,
    parameter logic [31:0] P_RATE_CYC = fpt_pkg::RATE_TICK_CYC,
    parameter logic [31:0] P_SHOW_CYC = fpt_pkg::SHOW_CYC,
    parameter logic [31:0] P_IDLE_CYC = fpt_pkg::IDLE_CYC,
    parameter logic [31:0] P_SEG_CYC  = fpt_pkg::SEG_STEP_CYC
) (
    // clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,
    input  wire logic        i_clk_en,
    // gear pulse and keys, active high
    input  wire logic        i_pulse,
    input  wire logic        i_key_reset,
    input  wire logic        i_key_cal,
    // configuration
    input  wire logic [15:0] i_k_partial,
    input  wire logic [15:0] i_k_total,
    input  wire logic        i_retain,
    // accumulators
    output logic      [31:0] o_partial,
    output logic      [31:0] o_rtotal,
    output logic      [31:0] o_ltotal,
    // display
    output logic      [19:0] o_lower_value,
    output logic             o_x10,
    output logic             o_x100,
    output logic             o_lower_is_lifetime,
    output logic             o_lower_is_reset,
    output logic             o_seg_all_on,
    output logic             o_seg_all_off,
    output logic             o_rate_mode,
    output logic      [31:0] o_rate,
    // status
    output logic             o_standby,
    output logic             o_counting
);

    ////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        fpt_pkg::fpt_state_t st;
        logic [31:0] part;
        logic [31:0] rtot;
        logic [31:0] ltot;
        logic [31:0] idle;
        logic [31:0] tmr;
        logic [31:0] krst;
        logic [31:0] kcal;
        logic [31:0] rwin;
        logic [31:0] rsum;
        logic [31:0] rate;
        logic [19:0] disp;
        logic        x10;
        logic        x100;
        logic        pprev;
        logic        rprev;
        logic        cprev;
        logic        armed;
        logic        clr_rt;
        logic        started;
        logic [1:0]  ridx;
        logic [1:0]  widx;
    } fpt_regs_t;

    fpt_regs_t s_q;
    fpt_regs_t s_d;

    logic [31:0] rd_data;
    logic [31:0] wr_data;
    logic        wr_en;

    ////////////////////////////////////////////////////////////////////////
    // functions

    // saturate so a total can never wrap back below its value
    function automatic logic [31:0] fpt_sat_add(input logic [31:0] a,
                                                input logic [31:0] b);
        logic [32:0] sum;
        sum = {1'b0, a} + {1'b0, b};
        return sum[32] ? 32'hFFFF_FFFF : sum[31:0];
    endfunction : fpt_sat_add

    function automatic logic [21:0] fpt_scale(input logic [31:0] v);
        if (v <= fpt_pkg::X1_LIMIT)
            return {2'b00, v[19:0]};
        else if (v <= fpt_pkg::X10_LIMIT)
            return {2'b01, 20'(v / 32'h0000_000A)};
        else if (v <= fpt_pkg::X100_LIMIT)
            return {2'b10, 20'(v / 32'h0000_0064)};
        else
            return {2'b10, fpt_pkg::DIGITS_MAX};
    endfunction : fpt_scale

    function automatic logic [31:0] fpt_per_min(input logic [31:0] cnt);
        return 32'((64'(cnt) * fpt_pkg::MS_PER_MIN) / fpt_pkg::RATE_DIV);
    endfunction : fpt_per_min

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        logic        p_edge;
        logic        r_edge;
        logic        cal_short;
        logic        counting;
        logic [31:0] inc_p;
        logic [31:0] inc_t;
        logic [31:0] sum_now;
        logic [31:0] lower;
        logic [21:0] sc;
        p_edge    = i_pulse & ~s_q.pprev;
        r_edge    = i_key_reset & ~s_q.rprev;
        cal_short = ~i_key_cal & s_q.cprev & (s_q.kcal < P_LONG_CYC);
        counting  = (s_q.idle != 32'h0000_0000) | p_edge;
        inc_p     = p_edge ? 32'(i_k_partial) : 32'h0000_0000;
        inc_t     = p_edge ? 32'(i_k_total) : 32'h0000_0000;
        sum_now   = s_q.rsum + inc_p;
        lower     = (s_q.st == fpt_pkg::ST_STANDBY ||
                     s_q.st == fpt_pkg::ST_RESTORE) ? s_q.ltot : s_q.rtot;
        sc        = fpt_scale(lower);
        s_d       = s_q;

        s_d.pprev = i_pulse;
        s_d.rprev = i_key_reset;
        s_d.cprev = i_key_cal;
        s_d.krst  = i_key_reset ? fpt_sat_add(s_q.krst, 32'h0000_0001)
                                : 32'h0000_0000;
        s_d.kcal  = i_key_cal ? fpt_sat_add(s_q.kcal, 32'h0000_0001)
                              : 32'h0000_0000;
        if (s_q.tmr != 32'h0000_0000)
            s_d.tmr = s_q.tmr - 32'h0000_0001;

        if (s_q.st != fpt_pkg::ST_RESTORE)
        begin
            s_d.part = fpt_sat_add(s_q.part, inc_p);
            s_d.rtot = fpt_sat_add(s_q.rtot, inc_t);
            s_d.ltot = fpt_sat_add(s_q.ltot, inc_t);
            if (p_edge)
                s_d.idle = P_IDLE_CYC;
            else if (s_q.idle != 32'h0000_0000)
                s_d.idle = s_q.idle - 32'h0000_0001;
            s_d.widx = (s_q.widx == fpt_pkg::NV_LTOTAL) ? fpt_pkg::NV_PARTIAL
                                                       : s_q.widx + 2'h1;
        end

        // sampling window for the rate, counted in partial units
        if (s_q.rwin >= P_RATE_CYC - 32'h0000_0001)
        begin
            s_d.rwin = 32'h0000_0000;
            s_d.rsum = 32'h0000_0000;
            if (s_q.st == fpt_pkg::ST_RATE)
                s_d.rate = fpt_per_min(sum_now);
        end
        else
        begin
            s_d.rwin = s_q.rwin + 32'h0000_0001;
            s_d.rsum = sum_now;
        end

        case (s_q.st)
            fpt_pkg::ST_RESTORE:
            begin
                if (!s_q.started)
                begin
                    s_d.started = 1'b1;
                    if (i_retain)
                        s_d.ridx = 2'h1;
                    else
                        s_d.st = fpt_pkg::ST_STANDBY;
                end
                else
                begin
                    // read data lags the address by one cycle
                    s_d.ridx = s_q.ridx + 2'h1;
                    case (s_q.ridx)
                        2'h1: s_d.part = rd_data;
                        2'h2: s_d.rtot = rd_data;
                        default:
                        begin
                            s_d.ltot = rd_data;
                            s_d.st   = fpt_pkg::ST_STANDBY;
                        end
                    endcase
                end
            end
            fpt_pkg::ST_STANDBY:
            begin
                if (p_edge)
                    s_d.st = fpt_pkg::ST_COUNT;
                else if (r_edge)
                begin
                    s_d.part   = inc_p;
                    s_d.clr_rt = 1'b0;
                    s_d.tmr    = P_SEG_CYC;
                    s_d.st     = fpt_pkg::ST_SEG_ON;
                end
                else if (cal_short)
                begin
                    s_d.rate = 32'h0000_0000;
                    s_d.st   = fpt_pkg::ST_RATE;
                end
            end
            fpt_pkg::ST_COUNT:
            begin
                // keys have no path out of here
                if (!counting)
                begin
                    s_d.tmr = P_SHOW_CYC;
                    s_d.st  = fpt_pkg::ST_POSTCNT;
                end
            end
            fpt_pkg::ST_POSTCNT:
            begin
                if (p_edge)
                    s_d.st = fpt_pkg::ST_COUNT;
                else if (s_q.tmr == 32'h0000_0000)
                    s_d.st = fpt_pkg::ST_STANDBY;
            end
            fpt_pkg::ST_SEG_ON:
            begin
                if (s_q.tmr == 32'h0000_0000)
                begin
                    s_d.tmr = P_SEG_CYC;
                    s_d.st  = fpt_pkg::ST_SEG_OFF;
                end
            end
            fpt_pkg::ST_SEG_OFF:
            begin
                if (s_q.tmr == 32'h0000_0000)
                begin
                    if (s_q.clr_rt)
                        s_d.rtot = inc_t;
                    s_d.clr_rt = 1'b0;
                    s_d.armed  = 1'b0;
                    s_d.tmr    = P_SHOW_CYC;
                    s_d.st     = fpt_pkg::ST_POSTCLR;
                end
            end
            fpt_pkg::ST_POSTCLR:
            begin
                if (p_edge)
                    s_d.st = fpt_pkg::ST_COUNT;
                else if (s_q.armed && i_key_reset &&
                         s_q.krst >= P_LONG_CYC - 32'h0000_0001)
                begin
                    s_d.armed  = 1'b0;
                    s_d.clr_rt = 1'b1;
                    s_d.tmr    = P_SEG_CYC;
                    s_d.st     = fpt_pkg::ST_SEG_ON;
                end
                else
                begin
                    // only a fresh press here may clear the resettable total
                    s_d.armed = r_edge | (s_q.armed & i_key_reset);
                    if (s_q.tmr == 32'h0000_0000 && !s_d.armed)
                        s_d.st = fpt_pkg::ST_STANDBY;
                end
            end
            fpt_pkg::ST_RATE:
            begin
                if (!counting)
                begin
                    if (cal_short)
                        s_d.st = fpt_pkg::ST_STANDBY;
                    else if (r_edge && s_q.rate == 32'h0000_0000)
                        s_d.part = inc_p;
                end
            end
            default:
                s_d.st = fpt_pkg::ST_STANDBY;
        endcase

        s_d.disp = sc[19:0];
        s_d.x10  = sc[20];
        s_d.x100 = sc[21];
    end

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            s_q      <= '0;
            s_q.st   <= fpt_pkg::ST_RESTORE;
            s_q.part <= fpt_pkg::RESET_VALUE;
            s_q.rtot <= fpt_pkg::RESET_VALUE;
            s_q.ltot <= fpt_pkg::RESET_VALUE;
        end
        else if (i_clk_en)
            s_q <= s_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // retained store, one word refreshed per cycle

    always_comb
    begin
        case (s_q.widx)
            fpt_pkg::NV_PARTIAL: wr_data = s_q.part;
            fpt_pkg::NV_RTOTAL:  wr_data = s_q.rtot;
            default:             wr_data = s_q.ltot;
        endcase
    end

    assign wr_en = (s_q.st != fpt_pkg::ST_RESTORE);

    fpt_nv_mem #(
        .WIDTH (32),
        .DEPTH (fpt_pkg::NV_DEPTH),
        .AW    (2)
    ) u_nv (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_clk_en  (i_clk_en),
        .i_we      (wr_en),
        .i_waddr   (s_q.widx),
        .i_wdata   (wr_data),
        .i_raddr   (s_q.ridx),
        .o_rdata   (rd_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign o_partial           = s_q.part;
    assign o_rtotal            = s_q.rtot;
    assign o_ltotal            = s_q.ltot;
    assign o_lower_value       = s_q.disp;
    assign o_x10               = s_q.x10;
    assign o_x100              = s_q.x100;
    assign o_rate              = s_q.rate;
    assign o_standby           = (s_q.st == fpt_pkg::ST_STANDBY);
    assign o_lower_is_lifetime = o_standby;
    assign o_lower_is_reset    = (s_q.st == fpt_pkg::ST_COUNT) ||
                                 (s_q.st == fpt_pkg::ST_POSTCNT) ||
                                 (s_q.st == fpt_pkg::ST_POSTCLR);
    assign o_seg_all_on        = (s_q.st == fpt_pkg::ST_SEG_ON);
    assign o_seg_all_off       = (s_q.st == fpt_pkg::ST_SEG_OFF);
    assign o_rate_mode         = (s_q.st == fpt_pkg::ST_RATE);
    assign o_counting          = (s_q.idle != 32'h0000_0000);

    ////////////////////////////////////////////////////////////////////////
    // checks

    logic p_edge_w;
    logic r_edge_w;
    assign p_edge_w = i_clk_en & i_pulse & ~s_q.pprev;
    assign r_edge_w = i_clk_en & i_key_reset & ~s_q.rprev;

    sequence seq_seg_on_end;
        s_q.st == fpt_pkg::ST_SEG_ON && s_q.tmr == 32'h0000_0000 && i_clk_en;
    endsequence

    sequence seq_seg_off_end;
        s_q.st == fpt_pkg::ST_SEG_OFF && s_q.tmr == 32'h0000_0000 && i_clk_en;
    endsequence

    AST_LIFE_NEVER_DROPS: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        $past(s_q.st) != fpt_pkg::ST_RESTORE |-> s_q.ltot >= $past(s_q.ltot))
        else $error("lifetime total decreased");

    AST_STANDBY_SHOWS_LIFE: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        o_standby |-> o_lower_is_lifetime && !o_lower_is_reset &&
        (!$past(o_standby) || !$past(i_clk_en) ||
         $past(s_q.ltot) > fpt_pkg::X1_LIMIT ||
         o_lower_value == $past(s_q.ltot[19:0])))
        else $error("standby not showing lifetime total");

    AST_COUNT_KEYS_IGNORED: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        s_q.st == fpt_pkg::ST_COUNT && o_counting && i_clk_en
        |=> s_q.st == fpt_pkg::ST_COUNT || s_q.st == fpt_pkg::ST_POSTCNT)
        else $error("key acted while counting");

    AST_STANDBY_RESET_CLEARS: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        o_standby && r_edge_w && !p_edge_w
        |=> s_q.part == 32'h0000_0000 && o_seg_all_on)
        else $error("reset press in standby did not clear partial");

    AST_SEG_TEST_ORDER: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        seq_seg_off_end |=> o_lower_is_reset && !o_seg_all_off)
        else $error("segment test order wrong");

    AST_SEG_ON_TO_OFF: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        seq_seg_on_end |=> o_seg_all_off)
        else $error("segments did not go off after all on");

    AST_RTOT_CLEAR_CAUSE: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        s_q.rtot < $past(s_q.rtot)
        |-> $past(s_q.st) == fpt_pkg::ST_SEG_OFF && $past(s_q.clr_rt))
        else $error("resettable total cleared without partial clear");

    AST_RATE_ENTRY: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        o_standby && i_clk_en && !p_edge_w && !r_edge_w &&
        !i_key_cal && s_q.cprev && s_q.kcal < P_LONG_CYC
        |=> o_rate_mode)
        else $error("short cal press in standby did not enter rate mode");

    AST_RATE_TOTALS_RUN: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        o_rate_mode && p_edge_w && s_q.ltot < 32'hFFF0_0000
        |=> s_q.ltot == $past(s_q.ltot) + 32'($past(i_k_total)))
        else $error("lifetime total stalled in rate mode");

    AST_RATE_ZERO_CLEAR: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        o_rate_mode && !o_counting && r_edge_w && !p_edge_w &&
        !(s_q.cprev && !i_key_cal) && s_q.rate == 32'h0000_0000
        |=> s_q.part == 32'h0000_0000 && o_rate_mode && !o_seg_all_on)
        else $error("rate mode clear failed");

    AST_SCALE_RANGE: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        o_lower_value <= fpt_pkg::DIGITS_MAX && !(o_x10 && o_x100))
        else $error("totals display out of six digit range");

endmodule : fpt_totalizer

/* bench/fpt_partner.sv */
// gear switch and push key model for the totalizer
`timescale 1ns/1ns

module fpt_partner (
    // clock
    input  wire logic i_sys_clk,
    // stimulus to the block
    output logic      o_pulse,
    output logic      o_key_reset,
    output logic      o_key_cal
);
    initial
    begin
        o_pulse     = 1'b0;
        o_key_reset = 1'b0;
        o_key_cal   = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // one cycle high, one low: fastest legal gear rate
    task automatic gear(input int n);
        repeat (n)
        begin
            @(negedge i_sys_clk) o_pulse = 1'b1;
            @(negedge i_sys_clk) o_pulse = 1'b0;
        end
    endtask : gear

    // a hold of a second or more counts as long
    task automatic key(input bit cal, input int cyc);
        @(negedge i_sys_clk);
        if (cal)
            o_key_cal = 1'b1;
        else
            o_key_reset = 1'b1;
        repeat (cyc) @(negedge i_sys_clk);
        o_key_cal   = 1'b0;
        o_key_reset = 1'b0;
    endtask : key
endmodule : fpt_partner

/* bench/test_fpt_totalizer.sv */
// self-checking bench for the flow pulse totalizer
`timescale 1ns/1ns

module test_fpt_totalizer;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        pulse, krst, kcal;
    logic [31:0] part, rtot, ltot, rate;
    logic [19:0] lval;
    logic        life, seg_on, seg_off, rmode, stby, cnt;
    logic        x10, x100, lis;
    logic        en     = 1'b1;
    logic        retain = 1'b0;
    logic [15:0] kp     = 16'h0003;
    logic [15:0] kt     = 16'h0005;
    int          failures = 0;
    int          tests_run = 0;

    initial
    begin
        forever #2 clk = ~clk;
    end

    fpt_partner PEER (.i_sys_clk(clk), .o_pulse(pulse),
        .o_key_reset(krst), .o_key_cal(kcal));

    // short counts keep the run brief
    fpt_totalizer #(.P_LONG_CYC(32'h0000_0014),
        .P_RATE_CYC(32'h0000_0010), .P_SHOW_CYC(32'h0000_001E),
        .P_IDLE_CYC(32'h0000_000A), .P_SEG_CYC(32'h0000_0005)) DUT (
        .i_sys_clk(clk), .i_rst(rst), .i_clk_en(en), .i_pulse(pulse),
        .i_key_reset(krst), .i_key_cal(kcal), .i_k_partial(kp),
        .i_k_total(kt), .i_retain(retain), .o_partial(part),
        .o_rtotal(rtot), .o_ltotal(ltot), .o_lower_value(lval),
        .o_x10(x10), .o_x100(x100), .o_lower_is_lifetime(life),
        .o_lower_is_reset(lis), .o_seg_all_on(seg_on),
        .o_seg_all_off(seg_off), .o_rate_mode(rmode), .o_rate(rate),
        .o_standby(stby), .o_counting(cnt));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : check

    task automatic complete_run();
        if (failures == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : complete_run

    task automatic to_standby();
        for (int i = 0; i < 120 && stby !== 1'b1; i++) @(negedge clk);
        @(negedge clk);
    endtask : to_standby

    ////////////////////////////////////////////////////////////////////////
    task automatic t_dispense();
        to_standby();
        check("lifetime shown", 1, life);
        PEER.gear(3);
        check("partial", 9, part);
        check("resettable", 15, rtot);
        PEER.key(1'b0, 2);
        check("partial kept", 9, part);
        check("no seg test", 0, seg_on);
        to_standby();
        check("lower value", 15, lval);
        check("lifetime back", 1, life);
    endtask : t_dispense

    task automatic t_clear();
        PEER.key(1'b0, 2);
        check("partial clr", 0, part);
        check("seg on", 1, seg_on);
        check("rtotal kept", 15, rtot);
        for (int i = 0; i < 20 && seg_off !== 1'b1; i++) @(negedge clk);
        check("seg off", 1, seg_off);
        for (int i = 0; i < 20 && seg_off === 1'b1; i++) @(negedge clk);
        PEER.key(1'b0, 25);
        for (int i = 0; i < 40 && lis !== 1'b1; i++)
            @(negedge clk);
        check("reset shown", 1, lis);
        check("rtotal clr", 0, rtot);
        check("ltotal kept", 15, ltot);
        to_standby();
    endtask : t_clear

    task automatic t_rate();
        int hit;
        PEER.key(1'b1, 2);
        repeat (2) @(negedge clk);
        check("rate mode", 1, rmode);
        PEER.gear(4);
        PEER.key(1'b1, 2);
        check("still rate", 1, rmode);
        check("rtotal up", 20, rtot);
        check("ltotal up", 35, ltot);
        for (int i = 0; i < 40 && rate === 32'h0000_0000; i++)
            @(negedge clk);
        check("rate seen", 1, 32'(rate != 0));
        // one to four pulses of weight 3 land in the first full window
        hit = 0;
        for (int n = 1; n <= 4; n++)
            if (rate == 32'(3 * n * 60000 / 700))
                hit = 1;
        check("rate units", 1, hit);
        for (int i = 0; i < 80 && (rate !== 0 || cnt !== 0); i++)
            @(negedge clk);
        PEER.key(1'b0, 2);
        check("rate clr", 0, part);
        check("no seg", 0, seg_on);
        PEER.key(1'b1, 2);
        repeat (2) @(negedge clk);
        check("normal", 1, stby);
    endtask : t_rate

    task automatic t_scale();
        kt = 16'hFFFF;
        PEER.gear(16);
        @(negedge clk);
        kt = 16'h0005;
        check("scaled", (20 + 16 * 65535) / 10, lval);
        check("x10", 1, x10);
        check("x100", 0, x100);
        check("count shown", 1, lis);
        check("counting", 1, cnt);
        to_standby();
        check("scaled life", (35 + 16 * 65535) / 10, lval);
        // a pulse while frozen must leave no trace
        en = 1'b0;
        PEER.gear(1);
        en = 1'b1;
        check("frozen", 35 + 16 * 65535, ltot);
    endtask : t_scale

    task automatic t_retain();
        repeat (4) @(negedge clk);
        rst    = 1'b1;
        retain = 1'b1;
        repeat (3) @(negedge clk);
        check("ltot in reset", 0, ltot);
        rst = 1'b0;
        to_standby();
        check("part kept", 48, part);
        check("rtot kept", 20 + 16 * 65535, rtot);
        check("ltot kept", 35 + 16 * 65535, ltot);
    endtask : t_retain

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (12) @(negedge clk);
        rst = 1'b0;
        t_dispense();
        t_clear();
        t_rate();
        t_scale();
        t_retain();
        complete_run();
    end

    // whole sequence needs well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge clk);
        failures++;
        complete_run();
    end
endmodule : test_fpt_totalizer
